// ==== rtl/frame_crc.sv ====
`include "touch_host_consts.svh"

module frame_crc (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // crc port
  crc_if.engine    c
);
  import touch_host_pkg::*;

  // running check; clear wins since a new frame always starts fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c.crc <= `CRC_INIT;
    end else if (c.clr) begin
      c.crc <= `CRC_INIT;
    end else if (c.en) begin
      c.crc <= crc8_step(c.crc, c.din);
    end
  end

endmodule : frame_crc

// ==== rtl/touch_host_ctrl.sv ====
// The register offsets and the APB slave port were chosen for this implementation.
`include "touch_host_consts.svh"

module touch_host_ctrl (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // transport toward the device
  output logic                        tx_valid,
  output touch_host_pkg::byte_t       tx_data,
  output logic                        tx_last,
  input  wire logic                   tx_ready,
  input  wire logic                   rx_valid,
  input  wire touch_host_pkg::byte_t  rx_data,
  output logic                        rx_ready,
  // device pins
  input  wire logic                   change_line_twowire_n,
  input  wire logic                   change_line_fourwire_n,
  output logic                        dev_reset_n
);
  import touch_host_pkg::*;

  state_e      state_reg;
  logic        spi_mode_reg;
  logic        safety_reg;
  byte_t       save_id_reg;
  logic [15:0] tgt_addr_reg;
  logic [2:0]  tgt_len_reg;
  logic [31:0] wdata_reg;
  logic [15:0] cmd_addr_reg;
  logic [15:0] msg_addr_reg;
  logic [15:0] pwr_addr_reg;
  logic [3:0]  last_op_reg;
  logic        done_reg;
  logic        msg_reg;
  logic        crc_err_reg;
  logic        seq_rep_reg;
  logic        seq_skip_reg;
  logic        save_pend_reg;
  logic        save_ok_reg;
  logic        refused_reg;
  logic        sleep_reg;
  logic        debug_reg;
  byte_t       f_kind_reg;
  logic [15:0] f_addr_reg;
  logic [2:0]  f_len_reg;
  logic [31:0] f_data_reg;
  logic [3:0]  pos_reg;
  byte_t       tx_data_reg;
  byte_t       tx_seq_reg;
  byte_t       rx_seq_exp_reg;
  logic        seq_seen_reg;
  logic [3:0]  rx_cnt_reg;
  logic [7:0]  rst_cnt_reg;
  logic        rst_n_reg;
  logic [31:0] prdata_reg;
  logic        tw_meta;
  logic        tw_sync;
  logic        fw_meta;
  logic        fw_sync;
  byte_t       msg_mem [0:7];

  logic        wr_acc;
  logic        idle;
  logic        ctrl_wr;
  logic        reg_wr;
  logic        st_wr;
  logic [3:0]  op_w;
  logic        refuse;
  logic        go;
  logic        chg_active;
  logic [3:0]  np;
  logic        tx_fire;
  logic        tx_end;
  logic        rx_fire;
  logic        rx_end;
  logic        rx_crc_ok;
  logic        rst_end;
  logic        done_set;

  crc_if crc_bus ();

  frame_crc u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (crc_bus)
  );

  // decode of the mapped offsets, used by the launch checks and error answer
  function automatic logic mapped(input logic [7:0] a);
    return (a == `A_CTRL) || (a == `A_CONFIG) || (a == `A_TARGET) ||
           (a == `A_WDATA) || (a == `A_OBJMAP) || (a == `A_PWRMAP) ||
           (a == `A_STATUS) || (a == `A_RDATA0) || (a == `A_RDATA1);
  endfunction : mapped

  // position that follows p in the frame being sent
  function automatic logic [3:0] next_pos(input logic [3:0] p);
    logic [3:0] n;
    n = p + 4'h1;
    if (p == `P_CRC) begin
      n = `P_END;
    end else if (p == `P_KIND && f_kind_reg == `FR_RESP) begin
      n = `P_CRC;
    end else if (n == `P_SEQ && spi_mode_reg) begin
      n = `P_ALO;
    end else if (n == `P_DAT && f_kind_reg != `FR_WRITE) begin
      n = `P_CRC;
    end else if (p >= `P_DAT && n == `P_DAT + {1'b0, f_len_reg}) begin
      n = `P_CRC;
    end
    if (n == `P_CRC && !safety_reg) begin
      n = `P_END;
    end
    return n;
  endfunction : next_pos

  // byte carried at position p, the crc byte aside
  function automatic byte_t byte_at(input logic [3:0] p);
    byte_t b;
    b = 8'h00;
    unique case (p)
      `P_KIND: b = f_kind_reg;
      `P_SEQ:  b = tx_seq_reg;
      `P_ALO:  b = f_addr_reg[7:0];
      `P_AHI:  b = f_addr_reg[15:8];
      `P_LEN:  b = {5'h00, f_len_reg};
      4'h5:    b = f_data_reg[7:0];
      4'h6:    b = f_data_reg[15:8];
      4'h7:    b = f_data_reg[23:16];
      4'h8:    b = f_data_reg[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : byte_at

  // bus strobes; zero wait states, so pready stays high
  assign wr_acc  = psel & penable & pwrite;
  assign idle    = (state_reg == S_IDLE);
  assign ctrl_wr = wr_acc & (paddr == `A_CTRL);
  assign st_wr   = wr_acc & (paddr == `A_STATUS);
  assign reg_wr  = wr_acc & idle;
  assign op_w    = pwdata[3:0];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata  = prdata_reg;

  // launch checks: one operation at a time, unsafe orders are refused
  always_comb begin
    refuse = 1'b0;
    if (ctrl_wr) begin
      if (!idle) begin
        refuse = 1'b1;
      end else if (op_w == `OP_RESET && save_pend_reg) begin
        refuse = 1'b1;
      end else if (op_w == `OP_DEBUG && safety_reg) begin
        refuse = 1'b1;
      end else if (op_w == `OP_WRITE &&
                   (tgt_len_reg == 3'h0 || tgt_len_reg > `MAX_LEN)) begin
        refuse = 1'b1;
      end else if (op_w > `OP_INTERVALS) begin
        refuse = 1'b1;
      end
    end else if (wr_acc && !idle && !st_wr && mapped(paddr)) begin
      refuse = 1'b1;  // settings must not move under a frame in flight
    end
  end
  assign go = ctrl_wr & ~refuse & (op_w != `OP_NOP);

  // the change line of the interface in use, after synchronising
  assign chg_active = spi_mode_reg ? ~fw_sync : ~tw_sync;

  // transport handshakes
  assign tx_valid = (state_reg == S_TX);
  assign tx_data  = tx_data_reg;
  assign np       = next_pos(pos_reg);
  assign tx_last  = tx_valid & (np == `P_END);
  assign tx_fire  = tx_valid & tx_ready;
  assign tx_end   = tx_fire & (np == `P_END);
  assign rx_ready = (state_reg == S_RX);
  assign rx_fire  = rx_ready & rx_valid;
  assign rx_end   = rx_fire & (rx_cnt_reg == `MSG_LAST);
  assign rx_crc_ok = (rx_data == crc_bus.crc);
  assign rst_end  = (state_reg == S_RESET) && (rst_cnt_reg == 8'h00);
  assign done_set = (tx_end & (f_kind_reg == `FR_WRITE)) | rx_end | rst_end;
  assign dev_reset_n = rst_n_reg;

  // crc engine shared by outgoing frames and incoming messages
  assign crc_bus.clr = go | (tx_end & (f_kind_reg != `FR_WRITE));
  assign crc_bus.en  = (tx_fire & (pos_reg != `P_CRC)) |
                       (rx_fire & (rx_cnt_reg != `MSG_LAST));
  assign crc_bus.din = (state_reg == S_TX) ? tx_data_reg : rx_data;

  // two flops on each change line pin before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_meta <= 1'b1;
      tw_sync <= 1'b1;
      fw_meta <= 1'b1;
      fw_sync <= 1'b1;
    end else begin
      tw_meta <= change_line_twowire_n;
      tw_sync <= tw_meta;
      fw_meta <= change_line_fourwire_n;
      fw_sync <= fw_meta;
    end
  end

  // read data is captured in the setup cycle for the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `A_CTRL:   prdata_reg <= {28'h000_0000, last_op_reg};
        `A_CONFIG: prdata_reg <= {16'h0000, save_id_reg, 6'h00,
                                  safety_reg, spi_mode_reg};
        `A_TARGET: prdata_reg <= {13'h0000, tgt_len_reg, tgt_addr_reg};
        `A_WDATA:  prdata_reg <= wdata_reg;
        `A_OBJMAP: prdata_reg <= {msg_addr_reg, cmd_addr_reg};
        `A_PWRMAP: prdata_reg <= {16'h0000, pwr_addr_reg};
        `A_STATUS: prdata_reg <= {20'h0_0000, debug_reg, sleep_reg,
                                  chg_active, refused_reg, save_ok_reg,
                                  save_pend_reg, seq_skip_reg, seq_rep_reg,
                                  crc_err_reg, msg_reg, done_reg, ~idle};
        `A_RDATA0: prdata_reg <= {msg_mem[3], msg_mem[2],
                                  msg_mem[1], msg_mem[0]};
        `A_RDATA1: prdata_reg <= {msg_mem[7], msg_mem[6],
                                  msg_mem[5], msg_mem[4]};
        default:   prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // software settings, all zero after reset, so nothing runs unasked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_mode_reg <= 1'b0;
      safety_reg   <= 1'b0;
      save_id_reg  <= 8'h00;
      tgt_addr_reg <= 16'h0000;
      tgt_len_reg  <= 3'h0;
      wdata_reg    <= 32'h0000_0000;
      cmd_addr_reg <= 16'h0000;
      msg_addr_reg <= 16'h0000;
      pwr_addr_reg <= 16'h0000;
      last_op_reg  <= `OP_NOP;
    end else if (reg_wr) begin
      unique case (paddr)
        `A_CONFIG: begin
          spi_mode_reg <= pwdata[0];
          safety_reg   <= pwdata[1];
          save_id_reg  <= pwdata[15:8];
        end
        `A_TARGET: begin
          tgt_addr_reg <= pwdata[15:0];
          tgt_len_reg  <= pwdata[18:16];
        end
        `A_WDATA:  wdata_reg <= pwdata;
        `A_OBJMAP: begin
          cmd_addr_reg <= pwdata[15:0];
          msg_addr_reg <= pwdata[31:16];
        end
        `A_PWRMAP: pwr_addr_reg <= pwdata[15:0];
        `A_CTRL:   last_op_reg <= go ? op_w : last_op_reg;
        default:   ;
      endcase
    end
  end

  // operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (go && op_w == `OP_READ) begin
            state_reg <= S_WAIT_CHG;
          end else if (go && op_w == `OP_RESET) begin
            state_reg <= S_RESET;
          end else if (go) begin
            state_reg <= S_TX;
          end
        end
        S_WAIT_CHG: begin
          // wait on the notification only; no message polling
          if (chg_active) begin
            state_reg <= S_TX;
          end
        end
        S_TX: begin
          if (tx_end && f_kind_reg == `FR_WRITE) begin
            state_reg <= S_IDLE;
          end else if (tx_end && !(f_kind_reg == `FR_READ && spi_mode_reg)) begin
            state_reg <= S_RX;
          end
        end
        S_RX: begin
          if (rx_end) begin
            state_reg <= S_IDLE;
          end
        end
        S_RESET: begin
          if (rst_end) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // frame contents, set at launch, kind turned to response after a four-wire read; writes are sent in issue order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_kind_reg <= `FR_WRITE;
      f_addr_reg <= 16'h0000;
      f_len_reg  <= 3'h0;
      f_data_reg <= 32'h0000_0000;
    end else if (go) begin
      f_kind_reg <= (op_w == `OP_READ) ? `FR_READ : `FR_WRITE;
      f_addr_reg <= tgt_addr_reg;
      f_len_reg  <= tgt_len_reg;
      f_data_reg <= wdata_reg;
      unique case (op_w)
        `OP_SAVE: begin
          f_addr_reg <= cmd_addr_reg + `CMD_SAVE_OFS;
          f_len_reg  <= 3'h1;
          f_data_reg <= {24'h00_0000, `CMD_SAVE_VAL};
        end
        `OP_DEBUG: begin
          f_addr_reg <= cmd_addr_reg + `CMD_DBG_OFS;
          f_len_reg  <= 3'h1;
          f_data_reg <= {24'h00_0000, `CMD_DBG_VAL};
        end
        `OP_SLEEP: begin
          f_addr_reg <= pwr_addr_reg + `PWR_IDLE_OFS;
          f_len_reg  <= 3'h2;
          f_data_reg <= 32'h0000_0000;
        end
        `OP_INTERVALS: begin
          f_addr_reg <= pwr_addr_reg + `PWR_IDLE_OFS;
          f_len_reg  <= 3'h2;
          f_data_reg <= {16'h0000, wdata_reg[15:0]};
        end
        `OP_READ: begin
          f_addr_reg <= msg_addr_reg;
          f_len_reg  <= 3'h0;
        end
        default: ;
      endcase
    end else if (tx_end && f_kind_reg == `FR_READ && spi_mode_reg) begin
      f_kind_reg <= `FR_RESP;
    end
  end

  // byte walker; the crc byte is folded one step ahead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg     <= `P_KIND;
      tx_data_reg <= 8'h00;
    end else if (go) begin
      pos_reg     <= `P_KIND;
      tx_data_reg <= (op_w == `OP_READ) ? `FR_READ : `FR_WRITE;
    end else if (tx_end && f_kind_reg == `FR_READ && spi_mode_reg) begin
      pos_reg     <= `P_KIND;
      tx_data_reg <= `FR_RESP;
    end else if (tx_fire && np != `P_END) begin
      pos_reg     <= np;
      tx_data_reg <= (np == `P_CRC) ?
                     crc8_step(crc_bus.crc, tx_data_reg) :
                     byte_at(np);
    end
  end

  // sequence numbering of outgoing two-wire frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_seq_reg <= 8'h00;
    end else if (tx_end && !spi_mode_reg) begin
      tx_seq_reg <= tx_seq_reg + 8'h01;
    end
  end

  // message capture; self test results arrive here too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_reg <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        msg_mem[i] <= 8'h00;
      end
    end else if (crc_bus.clr) begin
      rx_cnt_reg <= 4'h0;
    end else if (rx_fire) begin
      msg_mem[rx_cnt_reg[2:0]] <= rx_data;
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
    end
  end

  // expected message sequence, updated from every good message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_seq_exp_reg <= 8'h00;
      seq_seen_reg   <= 1'b0;
    end else if (rx_end && rx_crc_ok) begin
      rx_seq_exp_reg <= msg_mem[1] + 8'h01;
      seq_seen_reg   <= 1'b1;
    end
  end

  // sticky flags: an event in the clearing cycle still lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg     <= 1'b0;
      msg_reg      <= 1'b0;
      crc_err_reg  <= 1'b0;
      seq_rep_reg  <= 1'b0;
      seq_skip_reg <= 1'b0;
      save_ok_reg  <= 1'b0;
      refused_reg  <= 1'b0;
    end else begin
      done_reg    <= done_set | (done_reg & ~(st_wr & pwdata[`SB_DONE]));
      msg_reg     <= (rx_end & rx_crc_ok) |
                     (msg_reg & ~(st_wr & pwdata[`SB_MSG]));
      crc_err_reg <= (rx_end & ~rx_crc_ok) |
                     (crc_err_reg & ~(st_wr & pwdata[`SB_CRC_ERR]));
      seq_rep_reg <= (rx_end & rx_crc_ok & seq_seen_reg &
                      (msg_mem[1] == rx_seq_exp_reg - 8'h01)) |
                     (seq_rep_reg & ~(st_wr & pwdata[`SB_SEQ_REP]));
      seq_skip_reg <= (rx_end & rx_crc_ok & seq_seen_reg &
                       (msg_mem[1] != rx_seq_exp_reg) &
                       (msg_mem[1] != rx_seq_exp_reg - 8'h01)) |
                      (seq_skip_reg & ~(st_wr & pwdata[`SB_SEQ_SKIP]));
      save_ok_reg <= (rx_end & rx_crc_ok & save_pend_reg &
                      (msg_mem[0] == save_id_reg)) |
                     (save_ok_reg & ~(st_wr & pwdata[`SB_SAVE_OK]));
      refused_reg <= refuse |
                     (refused_reg & ~(st_wr & pwdata[`SB_REFUSED]));
    end
  end

  // save completion tracking; reset stays refused until the report lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_pend_reg <= 1'b0;
    end else if (go && op_w == `OP_SAVE) begin
      save_pend_reg <= 1'b1;
    end else if (rx_end && rx_crc_ok && msg_mem[0] == save_id_reg) begin
      save_pend_reg <= 1'b0;
    end
  end

  // sleep state shadow and debug port shadow; device reset turns debug off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
      debug_reg <= 1'b0;
    end else begin
      if (go && op_w == `OP_SLEEP) begin
        sleep_reg <= 1'b1;
      end else if (go && op_w == `OP_INTERVALS) begin
        sleep_reg <= 1'b0;
      end
      if (rst_end) begin
        debug_reg <= 1'b0;
      end else if (go && op_w == `OP_DEBUG) begin
        debug_reg <= 1'b1;
      end
    end
  end

  // device reset pulse of a fixed least width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_reg <= 8'h00;
      rst_n_reg   <= 1'b1;
    end else if (go && op_w == `OP_RESET) begin
      rst_cnt_reg <= 8'(`DEV_RST_CYC - 1);
      rst_n_reg   <= 1'b0;
    end else if (rst_end) begin
      rst_n_reg   <= 1'b1;
    end else if (state_reg == S_RESET) begin
      rst_cnt_reg <= rst_cnt_reg - 8'h01;
    end
  end

endmodule : touch_host_ctrl

// ==== shared/crc_if.sv ====
interface crc_if;
  logic       clr;
  logic       en;
  logic [7:0] din;
  logic [7:0] crc;
  modport engine (input clr, input en, input din, output crc);
  modport user   (output clr, output en, output din, input crc);
endinterface : crc_if

// ==== shared/touch_host_consts.svh ====
`ifndef TOUCH_HOST_CONSTS_SVH
`define TOUCH_HOST_CONSTS_SVH

// apb byte offsets of the controller registers
`define A_CTRL        8'h00
`define A_CONFIG      8'h04
`define A_TARGET      8'h08
`define A_WDATA       8'h0C
`define A_OBJMAP      8'h10
`define A_PWRMAP      8'h14
`define A_STATUS      8'h18
`define A_RDATA0      8'h1C
`define A_RDATA1      8'h20

// operation codes written to the control register
`define OP_NOP        4'h0
`define OP_WRITE      4'h1
`define OP_READ       4'h2
`define OP_SAVE       4'h3
`define OP_RESET      4'h4
`define OP_DEBUG      4'h5
`define OP_SLEEP      4'h6
`define OP_INTERVALS  4'h7

// status bit positions
`define SB_BUSY       0
`define SB_DONE       1
`define SB_MSG        2
`define SB_CRC_ERR    3
`define SB_SEQ_REP    4
`define SB_SEQ_SKIP   5
`define SB_SAVE_PEND  6
`define SB_SAVE_OK    7
`define SB_REFUSED    8
`define SB_CHG        9
`define SB_SLEEP      10
`define SB_DEBUG      11

// frame kinds and byte positions inside a frame
`define FR_WRITE      8'h01
`define FR_READ       8'h02
`define FR_RESP       8'h03
`define P_KIND        4'h0
`define P_SEQ         4'h1
`define P_ALO         4'h2
`define P_AHI         4'h3
`define P_LEN         4'h4
`define P_DAT         4'h5
`define P_CRC         4'h9
`define P_END         4'hF

// message layout: id, sequence, payload, crc
`define MSG_LAST      4'h7
`define MAX_LEN       3'h4

// field offsets inside objects and command values
`define CMD_SAVE_OFS  16'h0001
`define CMD_SAVE_VAL  8'h55
`define CMD_DBG_OFS   16'h0003
`define CMD_DBG_VAL   8'h01
`define PWR_IDLE_OFS  16'h0000

// frame check
`define CRC_POLY      8'h07
`define CRC_INIT      8'h00

// timing
`define CLK_NS        10
`define DEV_RST_NS    1000
`define DEV_RST_CYC   ((`DEV_RST_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== shared/touch_host_pkg.sv ====
`include "touch_host_consts.svh"

package touch_host_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_WAIT_CHG = 3'b001,
    S_TX       = 3'b010,
    S_RX       = 3'b011,
    S_RESET    = 3'b100
  } state_e;

  // one byte step of the frame check, msb first
  function automatic byte_t crc8_step(input byte_t c, input byte_t d);
    byte_t r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8_step

endpackage : touch_host_pkg

// ==== verification/touch_dev_model.sv ====
module touch_dev_model (
  // clock and device reset
  input wire logic       pclk,
  input wire logic       rst_n,
  // frames from the host
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  output logic           tx_ready,
  // messages to the host
  output logic           rx_valid,
  output logic [7:0]     rx_data,
  input wire logic       rx_ready,
  output logic           change_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [3:0] idx = 4'h0;
  logic [7:0] c = 8'h00;
  logic       pend = 1'b0;
  logic [7:0] tc = 8'h00;
  int         crc_hits = 0;
  function automatic logic [7:0] crc(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    r = a ^ d;
    repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : crc
  // stall every other cycle; a finished frame outside device reset raises the single pending message
  initial tx_ready = 1'b0;
  always @(posedge pclk) begin
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      tc <= tx_last ? 8'h00 : crc(tc, tx_data);
      if (tx_last && tx_data == tc) crc_hits++;
      if (tx_last) pend <= rst_n;
    end
    if (rx_valid && rx_ready) begin
      c <= idx == 4'h7 ? 8'h00 : crc(c, rx_data);
      idx <= idx == 4'h7 ? 4'h0 : idx + 4'h1;
      if (idx == 4'h7) pend <= 1'b0;
    end
  end
  // debug pins are the part's own and never driven from this side
  // a message may be any report, self-test results among them
  // self tests run inside the part; only their reports reach us
  // id, sequence, payload, then crc; junk outside a message
  assign rx_valid = pend;
  assign rx_data  = !pend ? ~c : idx == 4'h7 ? c : 8'h10 + idx;
  assign change_n = ~pend;
endmodule : touch_dev_model

// ==== verification/touch_host_ctrl_chk.sv ====
module touch_host_ctrl_chk
  import touch_host_pkg::*;
(
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // transport
  input wire logic                  tx_valid,
  input wire touch_host_pkg::byte_t tx_data,
  input wire logic                  tx_last,
  input wire logic                  tx_ready,
  input wire logic                  rx_ready,
  input wire logic                  dev_reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a device reset pulse must be long enough to settle the part
  sequence s_rst_hold;
    !dev_reset_n [*8];
  endsequence
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  AST_RST_HOLD: assert property (
    $fell(dev_reset_n) |-> s_rst_hold) else $error("short reset");
  AST_KIND_FIRST: assert property (
    $rose(tx_valid) |-> tx_data inside {8'h01, 8'h02, 8'h03})
    else $error("bad frame kind");
  AST_LAST_VALID: assert property (
    tx_last |-> tx_valid) else $error("last without valid");
  AST_RX_TX: assert property (
    rx_ready |-> !tx_valid) else $error("rx during tx");
  AST_SLVERR: assert property (
    psel && penable |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'b00))
    else $error("slverr");
  AST_PRDATA: assert property (
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read data");
  AST_PREADY: assert property (
    psel |-> pready) else $error("wait state");
endmodule : touch_host_ctrl_chk

bind touch_host_ctrl touch_host_ctrl_chk u_touch_host_ctrl_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_ready(tx_ready), .rx_ready(rx_ready),
  .dev_reset_n(dev_reset_n));

// ==== verification/touch_host_ctrl_tb_top.sv ====
`include "touch_host_consts.svh"

module touch_host_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic tx_valid, tx_last, tx_ready, rx_valid, rx_ready, chg_n, dev_reset_n;
  logic [7:0] paddr, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd;
  int mismatches, checks, cyc, n;
  logic spi = 1'b0;
  logic [7:0] fr[6] = '{8'h01, 8'h00, 8'h23, 8'h01, 8'h01, 8'h5A};
  touch_host_ctrl u_touch_host_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .change_line_twowire_n(chg_n | spi),
    .change_line_fourwire_n(chg_n | ~spi), .dev_reset_n(dev_reset_n));
  touch_dev_model u_touch_dev_model (.pclk(pclk), .rst_n(dev_reset_n),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .change_n(chg_n));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, a, e);
    end
  endtask : cmp
  task automatic wait_idle;
    rd = 32'h0000_0001;
    while (rd[`SB_BUSY] !== 1'b0) apb(1'b0, `A_STATUS, 0);
  endtask : wait_idle
  task automatic finish_test;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `A_CONFIG, 0);
    cmp(rd, 0);
    apb(1'b0, 8'h40, 0);
    cmp({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, `A_TARGET, 32'h0001_0123);
    apb(1'b1, `A_WDATA, 32'h0000_005A);
    apb(1'b1, `A_CTRL, `OP_WRITE);
    wait_idle();
    foreach (fr[i]) cmp(u_touch_dev_model.got[i], fr[i]);
    apb(1'b1, `A_CTRL, `OP_READ);
    wait_idle();
    cmp(rd[`SB_MSG], 1);
    apb(1'b0, `A_RDATA0, 0);
    cmp(rd, 32'h1312_1110);
    cmp(chg_n, 1);
    apb(1'b1, `A_TARGET, 32'h0000_0123);
    apb(1'b1, `A_CTRL, `OP_WRITE);
    apb(1'b0, `A_STATUS, 0);
    cmp(rd[`SB_REFUSED], 1);
    apb(1'b1, `A_CTRL, `OP_DEBUG);
    wait_idle();
    cmp(rd[`SB_DEBUG], 1);
    apb(1'b1, `A_CTRL, `OP_RESET);
    wait (dev_reset_n === 1'b0);
    while (dev_reset_n === 1'b0) begin
      @(posedge pclk);
      #1 n++;
    end
    cmp(n, `DEV_RST_CYC);
    apb(1'b0, `A_STATUS, 0);
    cmp(rd[`SB_DEBUG], 0);
    // four-wire with safety: save, guarded reset, two-step read, refused debug, sleep and intervals
    apb(1'b1, `A_CONFIG, 32'h0000_1003);
    spi <= 1'b1;
    n = u_touch_dev_model.crc_hits;
    apb(1'b1, `A_CTRL, `OP_SAVE);
    wait_idle();
    apb(1'b1, `A_CTRL, `OP_RESET);
    apb(1'b0, `A_STATUS, 0);
    cmp({rd[`SB_SAVE_PEND], dev_reset_n}, 2'b11);
    apb(1'b1, `A_CTRL, `OP_READ);
    wait_idle();
    cmp({rd[`SB_SAVE_OK], rd[`SB_SEQ_REP]}, 2'b11);
    cmp(u_touch_dev_model.crc_hits - n, 3);
    cmp(u_touch_dev_model.got.size(), 30);
    cmp(u_touch_dev_model.got[18], 8'h01);
    cmp(u_touch_dev_model.got[21], 8'h55);
    cmp(u_touch_dev_model.got[28], 8'h03);
    apb(1'b1, `A_CTRL, `OP_DEBUG);
    apb(1'b0, `A_STATUS, 0);
    cmp(rd[`SB_DEBUG], 0);
    apb(1'b1, `A_CTRL, `OP_SLEEP);
    wait_idle();
    cmp(rd[`SB_SLEEP], 1);
    apb(1'b1, `A_CTRL, `OP_INTERVALS);
    wait_idle();
    cmp(rd[`SB_SLEEP], 0);
    finish_test();
  end
endmodule : touch_host_ctrl_tb_top
